// ---- src/tcdma_pkg.sv ----
package tcdma_pkg;

   // register block decode: addr[7:5] picks the block, addr[4] the channel,
   // addr[3:1] the register inside the channel
   localparam logic [2:0] REG_BLOCK   = 3'h6;
   localparam int         BLK_HI      = 7;
   localparam int         BLK_LO      = 5;
   localparam int         CH_BIT      = 4;
   localparam int         SEL_HI      = 3;
   localparam int         SEL_LO      = 1;

   // register index inside a channel (printed offsets C0..CA and D0..DA)
   localparam logic [2:0] SEL_SRC_LO  = 3'h0;
   localparam logic [2:0] SEL_SRC_HI  = 3'h1;
   localparam logic [2:0] SEL_DST_LO  = 3'h2;
   localparam logic [2:0] SEL_DST_HI  = 3'h3;
   localparam logic [2:0] SEL_COUNT   = 3'h4;
   localparam logic [2:0] SEL_CTRL    = 3'h5;

   // control word fields
   localparam int         B_DST_MEM   = 15;
   localparam int         B_DST_DOWN  = 14;
   localparam int         B_DST_UP    = 13;
   localparam int         B_SRC_MEM   = 12;
   localparam int         B_SRC_DOWN  = 11;
   localparam int         B_SRC_UP    = 10;
   localparam int         B_TC_TERM   = 9;
   localparam int         B_INT_EN    = 8;
   localparam int         B_SYNC_HI   = 7;
   localparam int         B_SYNC_LO   = 6;
   localparam int         B_PRIO      = 5;
   localparam int         B_RUN_WE    = 2;
   localparam int         B_RUN       = 1;
   localparam int         B_WORD      = 0;

   // stored control bits; run and its write enable are handled apart
   localparam logic [15:0] CTRL_MASK  = 16'hFFE1;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [19:0] PTR_RST    = 20'h00000;
   localparam logic [15:0] COUNT_RST  = 16'h0000;
   localparam logic [15:0] COUNT_ONE  = 16'h0001;

   localparam logic [1:0] SYNC_NONE   = 2'h0;
   localparam logic [1:0] SYNC_SRC    = 2'h1;
   localparam logic [1:0] SYNC_DST    = 2'h2;

   // idle clocks after a destination-synchronised transfer
   localparam logic [1:0] DEST_GAP_CLKS = 2'h2;

   function automatic logic [19:0] step_ptr(input logic [19:0] p, input logic up,
                                            input logic down, input logic word);
      logic [19:0] d;
      d = word ? 20'h00002 : 20'h00001;
      if (up && !down)
         step_ptr = p + d;
      else if (down && !up)
         step_ptr = p - d;
      else
         step_ptr = p;
   endfunction

endpackage

// ---- src/tcdma_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcdma_chan (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        wr,
   input  wire logic [2:0]  sel,
   input  wire logic [15:0] wdata,
   input  wire logic        step,
   output logic      [15:0] rd_word,
   output logic      [19:0] src,
   output logic      [19:0] dst,
   output logic      [15:0] cnt,
   output logic      [15:0] ctrl,
   output logic             run,
   output logic             term
);

   logic word;

   assign word = ctrl[tcdma_pkg::B_WORD];
   // last transfer of a count-terminated run
   assign term = step && ctrl[tcdma_pkg::B_TC_TERM] && (cnt == tcdma_pkg::COUNT_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // pointers: a software write wins over the step in the same cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         src <= tcdma_pkg::PTR_RST;
      end else if (ce) begin
         if (wr && sel == tcdma_pkg::SEL_SRC_LO) begin
            src[15:0] <= wdata;
         end else if (wr && sel == tcdma_pkg::SEL_SRC_HI) begin
            src[19:16] <= wdata[3:0];
         end else if (step) begin
            src <= tcdma_pkg::step_ptr(src, ctrl[tcdma_pkg::B_SRC_UP],
                                       ctrl[tcdma_pkg::B_SRC_DOWN], word);
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dst <= tcdma_pkg::PTR_RST;
      end else if (ce) begin
         if (wr && sel == tcdma_pkg::SEL_DST_LO) begin
            dst[15:0] <= wdata;
         end else if (wr && sel == tcdma_pkg::SEL_DST_HI) begin
            dst[19:16] <= wdata[3:0];
         end else if (step) begin
            dst <= tcdma_pkg::step_ptr(dst, ctrl[tcdma_pkg::B_DST_UP],
                                       ctrl[tcdma_pkg::B_DST_DOWN], word);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= tcdma_pkg::COUNT_RST;
      end else if (ce) begin
         if (wr && sel == tcdma_pkg::SEL_COUNT)
            cnt <= wdata;
         else if (step)
            cnt <= cnt - tcdma_pkg::COUNT_ONE;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= tcdma_pkg::CTRL_RST;
      end else if (ce && wr && sel == tcdma_pkg::SEL_CTRL) begin
         ctrl <= wdata & tcdma_pkg::CTRL_MASK;
      end
   end

   // run bit: write only with its write enable; software write beats termination
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run <= 1'b0;
      end else if (ce) begin
         if (wr && sel == tcdma_pkg::SEL_CTRL && wdata[tcdma_pkg::B_RUN_WE])
            run <= wdata[tcdma_pkg::B_RUN];
         else if (term)
            run <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      case (sel)
         tcdma_pkg::SEL_SRC_LO: rd_word = src[15:0];
         tcdma_pkg::SEL_SRC_HI: rd_word = {12'h000, src[19:16]};
         tcdma_pkg::SEL_DST_LO: rd_word = dst[15:0];
         tcdma_pkg::SEL_DST_HI: rd_word = {12'h000, dst[19:16]};
         tcdma_pkg::SEL_COUNT:  rd_word = cnt;
         tcdma_pkg::SEL_CTRL: begin
            rd_word = ctrl;
            rd_word[tcdma_pkg::B_RUN] = run;
         end
         default:               rd_word = 16'h0000;
      endcase
   end

endmodule
`default_nettype wire

// ---- src/tcdma_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcdma_top (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [1:0]  dma_request_input,
   input  wire logic        hold_req,
   input  wire logic        cpu_locked,
   input  wire logic        cpu_cycle_active,
   input  wire logic        nmi,
   input  wire logic        bus_ready,
   input  wire logic [15:0] bus_rdata,
   output logic      [19:0] bus_addr,
   output logic             bus_mem,
   output logic             bus_rd,
   output logic             bus_wr,
   output logic             bus_word,
   output logic      [15:0] bus_wdata,
   output logic             dma_active,
   output logic      [1:0]  dma_irq
);

   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_STORE} tcdma_state_t;

   tcdma_state_t state;
   logic [15:0]  rd_word [2];
   logic [19:0]  src     [2];
   logic [19:0]  dst     [2];
   logic [15:0]  cnt     [2];
   logic [15:0]  ctrl    [2];
   logic [1:0]   gap     [2];
   logic [1:0]   sync_m  [2];
   logic [1:0]   run;
   logic [1:0]   term;
   logic [1:0]   step;
   logic [1:0]   wr_ch;
   logic [1:0]   elig;
   logic         blk_hit;
   logic         rd_ch;
   logic [2:0]   sel;
   logic         cur;
   logic         last;
   logic         half;
   logic         pick;
   logic         start;
   logic         word;
   logic         ssplit;
   logic         dsplit;
   logic         fetch_end;
   logic         xfer_done;

   ////////////////////////////////////////////////////////////////////////////
   // register port

   assign blk_hit = reg_addr[tcdma_pkg::BLK_HI:tcdma_pkg::BLK_LO] == tcdma_pkg::REG_BLOCK;
   assign rd_ch   = reg_addr[tcdma_pkg::CH_BIT];
   assign sel     = reg_addr[tcdma_pkg::SEL_HI:tcdma_pkg::SEL_LO];

   // read data live for exactly the cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         if (reg_rd && blk_hit)
            reg_rdata <= rd_word[rd_ch];
         else
            reg_rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channels

   for (genvar i = 0; i < 2; i++) begin : g_ch
      assign wr_ch[i]  = reg_wr && blk_hit && (rd_ch == 1'(i));
      assign step[i]   = xfer_done && (cur == 1'(i));
      assign sync_m[i] = ctrl[i][tcdma_pkg::B_SYNC_HI:tcdma_pkg::B_SYNC_LO];

      tcdma_chan u_chan (
         .mclk    (mclk),
         .arst_n  (arst_n),
         .ce      (ce),
         .wr      (wr_ch[i]),
         .sel     (sel),
         .wdata   (reg_wdata),
         .step    (step[i]),
         .rd_word (rd_word[i]),
         .src     (src[i]),
         .dst     (dst[i]),
         .cnt     (cnt[i]),
         .ctrl    (ctrl[i]),
         .run     (run[i]),
         .term    (term[i])
      );

      // the gap lets a destination drop its request before the next cycle
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            gap[i] <= 2'h0;
         end else if (ce) begin
            if (step[i] && sync_m[i] == tcdma_pkg::SYNC_DST)
               gap[i] <= tcdma_pkg::DEST_GAP_CLKS;
            else if (gap[i] != 2'h0)
               gap[i] <= gap[i] - 2'h1;
         end
      end

      // unused sync code 11 never transfers
      always_comb begin
         case (sync_m[i])
            tcdma_pkg::SYNC_NONE: elig[i] = run[i];
            tcdma_pkg::SYNC_SRC:  elig[i] = run[i] && dma_request_input[i];
            tcdma_pkg::SYNC_DST:  elig[i] = run[i] && dma_request_input[i]
                                            && (gap[i] == 2'h0);
            default:              elig[i] = 1'b0;
         endcase
      end

      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n)
            dma_irq[i] <= 1'b0;
         else if (ce)
            dma_irq[i] <= term[i] && ctrl[i][tcdma_pkg::B_INT_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbitration

   function automatic logic arb(input logic [1:0] e, input logic p0, input logic p1,
                                input logic lst);
      if (e == 2'h3)
         arb = (p0 != p1) ? p1 : ~lst;
      else
         arb = e[1];
   endfunction

   assign pick = arb(elig, ctrl[0][tcdma_pkg::B_PRIO], ctrl[1][tcdma_pkg::B_PRIO], last);

   // plain interrupts have no say here, only nmi
   assign start = (state == S_IDLE) && (elig != 2'h0) && !hold_req && !nmi
                  && !cpu_locked && !cpu_cycle_active;

   assign word   = ctrl[cur][tcdma_pkg::B_WORD];
   assign ssplit = word && src[cur][0];
   assign dsplit = word && dst[cur][0];

   assign fetch_end = (state == S_FETCH) && bus_rd && bus_ready && !(ssplit && !half);
   assign xfer_done = (state == S_STORE) && bus_wr && bus_ready && !(dsplit && !half);

   ////////////////////////////////////////////////////////////////////////////
   // bus sequencer

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state      <= S_IDLE;
         cur        <= 1'b0;
         last       <= 1'b0;
         half       <= 1'b0;
         bus_addr   <= tcdma_pkg::PTR_RST;
         bus_mem    <= 1'b0;
         bus_rd     <= 1'b0;
         bus_wr     <= 1'b0;
         bus_word   <= 1'b0;
         dma_active <= 1'b0;
      end else if (ce) begin
         case (state)
            S_IDLE: begin
               if (start) begin
                  cur        <= pick;
                  last       <= pick;
                  half       <= 1'b0;
                  bus_addr   <= src[pick];
                  bus_mem    <= ctrl[pick][tcdma_pkg::B_SRC_MEM];
                  bus_word   <= ctrl[pick][tcdma_pkg::B_WORD] && !src[pick][0];
                  bus_rd     <= 1'b1;
                  dma_active <= 1'b1;
                  state      <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (bus_rd && bus_ready) begin
                  if (ssplit && !half) begin
                     // second byte of an odd word, no CPU cycle in between
                     half     <= 1'b1;
                     bus_addr <= bus_addr + 20'h00001;
                     bus_word <= 1'b0;
                  end else begin
                     half     <= 1'b0;
                     bus_rd   <= 1'b0;
                     bus_addr <= dst[cur];
                     bus_mem  <= ctrl[cur][tcdma_pkg::B_DST_MEM];
                     bus_word <= word && !dst[cur][0];
                     bus_wr   <= !hold_req;
                     state    <= S_STORE;
                  end
               end
            end
            S_STORE: begin
               if (!bus_wr) begin
                  if (!hold_req)
                     bus_wr <= 1'b1;
               end else if (bus_ready) begin
                  if (dsplit && !half) begin
                     half     <= 1'b1;
                     bus_addr <= bus_addr + 20'h00001;
                     bus_word <= 1'b0;
                  end else begin
                     // bus is handed back after every transfer
                     half       <= 1'b0;
                     bus_wr     <= 1'b0;
                     dma_active <= 1'b0;
                     state      <= S_IDLE;
                  end
               end
            end
            default: begin
               state  <= S_IDLE;
               bus_rd <= 1'b0;
               bus_wr <= 1'b0;
            end
         endcase
      end
   end

   // the fetched data doubles as the store data; bytes travel on the low lane
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bus_wdata <= 16'h0000;
      end else if (ce) begin
         if (state == S_FETCH && bus_rd && bus_ready) begin
            if (!word)
               bus_wdata[7:0] <= bus_rdata[7:0];
            else if (!ssplit)
               bus_wdata <= bus_rdata;
            else if (!half)
               bus_wdata[7:0] <= bus_rdata[7:0];
            else
               bus_wdata[15:8] <= bus_rdata[7:0];
         end else if (state == S_STORE && bus_wr && bus_ready && dsplit && !half) begin
            bus_wdata <= {8'h00, bus_wdata[15:8]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   sequence s_fetch_end;
      ce && fetch_end;
   endsequence

   sequence s_dst_done;
      ce && step[0] && (sync_m[0] == tcdma_pkg::SYNC_DST);
   endsequence

   sequence s_ch0_held_off;
      ce && (state == S_IDLE || cur != 1'b0);
   endsequence

   a_hold_blocks_start: assert property (
      (ce && state == S_IDLE && hold_req) |=> !bus_rd)
      else $error("dma started during bus hold");

   a_lock_blocks_start: assert property (
      (ce && state == S_IDLE && cpu_locked) |=> !bus_rd)
      else $error("dma started inside a locked sequence");

   a_nmi_halts: assert property (
      (ce && state == S_IDLE && nmi) |=> !bus_rd && state == S_IDLE)
      else $error("dma started while nmi pending");

   a_run_needed: assert property (
      (ce && state == S_IDLE && run == 2'h0) |=> !bus_rd)
      else $error("dma started with both channels stopped");

   a_count_steps: assert property (
      (ce && step[0] && !wr_ch[0]) |=> cnt[0] == $past(cnt[0]) - tcdma_pkg::COUNT_ONE)
      else $error("count did not step after a transfer");

   a_term_stops: assert property (
      (ce && step[0] && ctrl[0][tcdma_pkg::B_TC_TERM] && cnt[0] == tcdma_pkg::COUNT_ONE
       && !wr_ch[0]) |=> !run[0] && cnt[0] == tcdma_pkg::COUNT_RST)
      else $error("channel kept running at zero count");

   a_term_irq: assert property (
      (ce && term[0] && ctrl[0][tcdma_pkg::B_INT_EN]) |=> dma_irq[0])
      else $error("no interrupt on terminal count");

   a_dest_gap: assert property (
      s_dst_done |=> s_ch0_held_off [*2])
      else $error("destination channel restarted inside its gap");

   a_fetch_store: assert property (
      s_fetch_end |=> state == S_STORE && !bus_rd && bus_addr == $past(dst[cur]))
      else $error("store cycle did not follow the fetch");

   a_nochg_keeps: assert property (
      (ce && wr_ch[0] && sel == tcdma_pkg::SEL_CTRL && !reg_wdata[tcdma_pkg::B_RUN_WE]
       && !term[0]) |=> run[0] == $past(run[0]))
      else $error("run bit changed without its write enable");

   a_prio_high: assert property (
      (ce && start && elig == 2'h3 && ctrl[0][tcdma_pkg::B_PRIO]
       != ctrl[1][tcdma_pkg::B_PRIO]) |=> cur == $past(ctrl[1][tcdma_pkg::B_PRIO]) && bus_rd)
      else $error("low priority channel won arbitration");

   a_equal_alt: assert property (
      (ce && start && elig == 2'h3 && ctrl[0][tcdma_pkg::B_PRIO]
       == ctrl[1][tcdma_pkg::B_PRIO]) |=> cur != $past(last))
      else $error("equal priority channels did not alternate");

endmodule
`default_nettype wire

// ---- dv/tcdma_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcdma_bus_model (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        slow,
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_mem,
   input  wire logic        bus_rd,
   input  wire logic        bus_wr,
   input  wire logic [15:0] bus_wdata,
   output logic             bus_ready,
   output logic      [15:0] bus_rdata
);
   logic [1:0]  dly;
   logic [15:0] last;
   logic [7:0]  rd_cnt;
   logic [7:0]  wr_cnt;
   logic [20:0] log_addr [0:63];
   logic [15:0] log_data [0:63];
   ////////////////////////////////////////////////////////////
   // released lines show the inverse of the last value, never a stale copy
   assign bus_rdata = bus_rd ? {(bus_addr[7:0] + 8'h01) ^ 8'h5A, bus_addr[7:0] ^ 8'h5A} : ~last;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dly       <= 2'h0;
         bus_ready <= 1'b0;
         rd_cnt    <= 8'h00;
         wr_cnt    <= 8'h00;
         last      <= 16'h0000;
      end else begin
         if (bus_ready && bus_rd)
            rd_cnt <= rd_cnt + 8'h01;
         if (bus_ready && bus_wr) begin
            log_addr[wr_cnt[5:0]] <= {bus_mem, bus_addr};
            log_data[wr_cnt[5:0]] <= bus_wdata;
            wr_cnt                <= wr_cnt + 8'h01;
         end
         if (bus_rd)
            last <= bus_rdata;
         // slow adds one wait state to every access
         dly       <= (bus_ready || !(bus_rd || bus_wr)) ? 2'h0 : dly + 2'h1;
         bus_ready <= !bus_ready && (bus_rd || bus_wr) && dly >= {1'b0, slow};
      end
   end
endmodule
`default_nettype wire

// ---- dv/tcdma_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcdma_top_bench;
   logic        mclk, arst_n, ce, reg_wr, reg_rd, slow;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, bus_rdata, bus_wdata;
   logic [1:0]  req, dma_irq;
   logic [3:0]  blk;
   logic [19:0] bus_addr;
   logic        bus_mem, bus_rd, bus_wr, bus_word, bus_ready, dma_active;
   int          num_errors, checks_done, irq0, words, r, n, i, k, p;

   tcdma_top i_tcdma_top (.mclk(mclk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .dma_request_input(req), .hold_req(blk[1]), .cpu_locked(blk[2]),
      .cpu_cycle_active(blk[3]), .nmi(blk[0]), .bus_ready(bus_ready), .bus_rdata(bus_rdata),
      .bus_addr(bus_addr), .bus_mem(bus_mem), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_word(bus_word), .bus_wdata(bus_wdata), .dma_active(dma_active), .dma_irq(dma_irq));
   tcdma_bus_model i_tcdma_bus_model (.mclk(mclk), .arst_n(arst_n), .slow(slow),
      .bus_addr(bus_addr), .bus_mem(bus_mem), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rdata(bus_rdata));
   ////////////////////////////////////////////////////////////
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (dma_irq[0] === 1'b1) irq0++;
   // completed accesses that used the full 16-bit lane
   always @(posedge mclk) if (bus_ready && (bus_rd || bus_wr) && bus_word === 1'b1) words++;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic setup(input logic [7:0] b, input logic [19:0] s, input logic [19:0] d,
                        input logic [15:0] c, input logic [15:0] ctl);
      wr(b, s[15:0]);
      wr(b + 8'h02, {12'h000, s[19:16]});
      wr(b + 8'h04, d[15:0]);
      wr(b + 8'h06, {12'h000, d[19:16]});
      wr(b + 8'h08, c);
      wr(b + 8'h0A, ctl);
   endtask
   task automatic wait_wr(input int m);
      k = 0;
      while ((int'(i_tcdma_bus_model.wr_cnt) != m || dma_active !== 1'b0) && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      check(24'(k == 2000), 24'h000000);
   endtask
   task automatic wait_rd(input int m);
      k = 0;
      while (int'(i_tcdma_bus_model.rd_cnt) == m && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      check(24'(k == 2000), 24'h000000);
   endtask
   task automatic conclude;
      if (num_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      conclude();
   end
   initial begin
      mclk = 0; arst_n = 0; ce = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      req = 0; blk = 0; slow = 0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      rd(8'hC8, 16'h0000);
      rd(8'hCA, 16'h0000);
      wr(8'hD2, 16'hFFF5);
      rd(8'hD2, 16'h0005);
      rd(8'h20, 16'h0000);
      // unsynchronised bytes, source up in memory, destination down in I/O
      setup(8'hC0, 20'h12340, 20'h00051, 16'h0002, 16'h5706);
      wait_wr(2);
      check(i_tcdma_bus_model.log_addr[0], 24'h000051);
      check(i_tcdma_bus_model.log_data[0][7:0], 24'h00001A);
      check(i_tcdma_bus_model.log_addr[1], 24'h000050);
      check(i_tcdma_bus_model.log_data[1][7:0], 24'h00001B);
      rd(8'hC0, 16'h2342);
      rd(8'hC8, 16'h0000);
      rd(8'hCA, 16'h5700);
      check(24'(irq0), 24'h000001);
      // odd word source held still, slow partner
      slow <= 1'b1;
      r = int'(i_tcdma_bus_model.rd_cnt);
      setup(8'hD0, 20'h00101, 20'h00200, 16'h0001, 16'hBE07);
      wait_wr(3);
      check(i_tcdma_bus_model.log_addr[2], 24'h100200);
      check(i_tcdma_bus_model.log_data[2], 24'h00585B);
      check(24'(int'(i_tcdma_bus_model.rd_cnt) - r), 24'h000002);
      check(24'(words), 24'h000001);
      rd(8'hD0, 16'h0101);
      rd(8'hD4, 16'h0202);
      slow <= 1'b0;
      // source-synchronised, count runs on without terminating
      setup(8'hC0, 20'h00300, 20'h00400, 16'h0005, 16'h8046);
      r = int'(i_tcdma_bus_model.rd_cnt);
      repeat (20) @(posedge mclk);
      check(24'(i_tcdma_bus_model.rd_cnt), 24'(r));
      req <= 2'b01;
      wait_rd(r);
      req <= 2'b00;
      wait_wr(4);
      rd(8'hC8, 16'h0004);
      wr(8'hCA, 16'h8040);
      rd(8'hCA, 16'h8042);
      wr(8'hCA, 16'h8044);
      rd(8'hCA, 16'h8040);
      // destination-synchronised, each blocker held in turn
      setup(8'hC0, 20'h00500, 20'h00501, 16'h0001, 16'h0286);
      r = int'(i_tcdma_bus_model.rd_cnt);
      repeat (20) @(posedge mclk);
      check(24'(i_tcdma_bus_model.rd_cnt), 24'(r));
      req <= 2'b01;
      for (i = 0; i < 4; i++) begin
         blk <= 4'h1 << i;
         repeat (20) @(posedge mclk);
         check(24'(i_tcdma_bus_model.rd_cnt), 24'(r));
      end
      blk <= 4'h0;
      wait_rd(r);
      req <= 2'b00;
      wait_wr(5);
      // both channels released together, equal then channel 1 higher
      for (p = 0; p < 2; p++) begin
         n = int'(i_tcdma_bus_model.wr_cnt);
         blk <= 4'h4;
         setup(8'hC0, 20'h00000, 20'h00600, 16'h0002, 16'hA206);
         setup(8'hD0, 20'h00000, 20'h00700, 16'h0002, 16'hA206 | {10'h000, p[0], 5'h00});
         blk <= 4'h0;
         wait_wr(n + 4);
         for (i = 0; i < 4; i++)
            check(i_tcdma_bus_model.log_addr[n + i][8],
                  p[0] ? 24'(i < 2) : 24'(i_tcdma_bus_model.log_addr[n][8] ^ i[0]));
      end
      // a running channel frozen by ce, then cut short by reset
      setup(8'hC0, 20'h00000, 20'h00800, 16'h0000, 16'h8006);
      repeat (4) @(posedge mclk);
      ce <= 1'b0;
      repeat (10) @(posedge mclk);
      check({22'h000000, dma_active, bus_wr}, 24'h000003);
      arst_n <= 1'b0;
      ce     <= 1'b1;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      rd(8'hCA, 16'h0000);
      // the unused sync code must never start a transfer
      wr(8'hDA, 16'h00C6);
      repeat (20) @(posedge mclk);
      check(24'(i_tcdma_bus_model.rd_cnt), 24'h000000);
      check({21'h000000, dma_active, bus_rd, bus_wr}, 24'h000000);
      conclude();
   end
endmodule
`default_nettype wire
